// ===== src/mbpa_pkg.sv
// shared constants and state codes for the multiplex bus poll arbiter
package mbpa_pkg;
  localparam int NPORT          = 4;
  localparam int IDX_W          = 2;
  localparam int WORD_W         = 8;
  localparam int FRAME_BITS     = 2 * WORD_W;
  localparam int NBIT_W         = 5;
  localparam int CNT_W          = 8;
  localparam int TMR_W          = 16;
  // timing: worst port-to-port propagation allowance
  localparam int CLK_PERIOD_NS  = 20;
  localparam int SETTLE_NS      = 100;
  localparam int SETTLE_CYC     = (SETTLE_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int BIT_CYC        = 2 * SETTLE_CYC;
  localparam int RX_FIRST_CYC   = SETTLE_CYC + BIT_CYC / 2;
  localparam int ACK_WAIT_CYC   = 64;
  localparam int GRANT_WAIT_CYC = 32;
  localparam int GO_HOLD_CYC    = 2 * SETTLE_CYC;
  // controller states, gray along ask/grant/xfer/gap
  typedef enum logic [2:0] {
    C_IDLE   = 3'h0,
    C_ASK    = 3'h1,
    C_GRANT  = 3'h3,
    C_XFER   = 3'h2,
    C_GAP    = 3'h6,
    C_LAUNCH = 3'h4
  } mbpa_ctl_state_t;
  // port transmit states
  typedef enum logic [2:0] {
    T_IDLE  = 3'h0,
    T_WAIT  = 3'h1,
    T_LEAD  = 3'h3,
    T_SHIFT = 3'h2,
    T_ACK   = 3'h6,
    T_REL   = 3'h7
  } mbpa_tx_state_t;
endpackage : mbpa_pkg

// ===== src/mbpa_bus_if.sv
// shared bus wiring between the controller and the ports
`timescale 1ns/10ps
interface mbpa_bus_if;
  localparam int N = mbpa_pkg::NPORT;
  logic         poll_mode;
  logic [N-1:0] poll_sel;
  logic [N-1:0] grant;
  logic         go;
  wire  [N-1:0] req;
  wire  [N-1:0] nodata;
  wire  [N-1:0] pass;
  wire  [N:0]   chain;
  wire  [N-1:0] data_out;
  wire  [N-1:0] data_oe_n;
  wire  [N-1:0] busy_out;
  wire  [N-1:0] busy_oe_n;
  wire  [N-1:0] ack_out;
  wire  [N-1:0] ack_oe_n;
  wire          data_line;
  wire          busy_line;
  wire          ack_line;
  ////////////////////////////////////////////////////////////////////////
  // enable chain: controller feeds slot 0, port i feeds slot i+1
  assign chain = {pass, go};
  // open-drain lines idle high, pulled low by any enabled driver
  assign data_line = ~|(~data_oe_n & ~data_out);
  assign busy_line = ~|(~busy_oe_n & ~busy_out);
  assign ack_line  = ~|(~ack_oe_n & ~ack_out);
  modport ctrl (
    output poll_mode, poll_sel, grant, go,
    input  req, nodata, chain, data_line, busy_line, ack_line
  );
  modport port (
    input  poll_mode, poll_sel, grant, chain,
    input  data_line, busy_line, ack_line,
    output req, nodata, pass,
    output data_out, data_oe_n, busy_out, busy_oe_n, ack_out, ack_oe_n
  );
endinterface : mbpa_bus_if

// ===== src/mbpa_ctrl.sv
// bus controller end: poller, chain launcher and serial frame monitor
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////
// serial frame receiver shared by the controller and the ports
module mbpa_rx (
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        busy_line_i,
  input  wire logic                        data_line_i,
  input  wire logic                        ignore_i,
  output logic                             done_o,
  output logic [mbpa_pkg::WORD_W-1:0]      dest_o,
  output logic [mbpa_pkg::WORD_W-1:0]      data_o
);
  localparam int W  = mbpa_pkg::WORD_W;
  localparam int FB = mbpa_pkg::FRAME_BITS;
  localparam int CW = mbpa_pkg::CNT_W;
  localparam int NW = mbpa_pkg::NBIT_W;

  typedef struct packed {
    logic          active;
    logic [CW-1:0] phase;
    logic [NW-1:0] nbit;
    logic [FB-1:0] shift;
    logic          done;
    logic [W-1:0]  dest;
    logic [W-1:0]  data;
  } mbpa_rx_regs_t;

  mbpa_rx_regs_t r_reg;
  mbpa_rx_regs_t r_next;

  ////////////////////////////////////////////////////////////////////////
  // busy low marks a live frame, so idle high data never counts
  always_comb begin
    r_next      = r_reg;
    r_next.done = 1'h0;
    if (busy_line_i) begin
      r_next.active = 1'h0;
    end else if (!r_reg.active) begin
      r_next.active = 1'h1;
      r_next.phase  = CW'(mbpa_pkg::RX_FIRST_CYC - 1);
      r_next.nbit   = '0;
    end else if (r_reg.nbit != NW'(FB)) begin
      if (r_reg.phase == '0) begin
        // low on the line is a one, high is a zero
        r_next.shift = {r_reg.shift[FB-2:0], ~data_line_i};
        r_next.phase = CW'(mbpa_pkg::BIT_CYC - 1);
        r_next.nbit  = NW'(r_reg.nbit + NW'(1));
        if (r_reg.nbit == NW'(FB - 1) && !ignore_i) begin
          // serial word pair back to parallel
          r_next.done = 1'h1;
          r_next.dest = r_next.shift[FB-1:W];
          r_next.data = r_next.shift[W-1:0];
        end
      end else begin
        r_next.phase = CW'(r_reg.phase - CW'(1));
      end
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign done_o = r_reg.done;
  assign dest_o = r_reg.dest;
  assign data_o = r_reg.data;
endmodule : mbpa_rx

////////////////////////////////////////////////////////////////////////////
module mbpa_ctrl (
  input  wire logic                         REF_CLK_I,
  input  wire logic                         RESET_N_I,
  input  wire logic                         ENABLE_I,
  input  wire logic                         POLL_MODE_I,
  input  wire logic [mbpa_pkg::TMR_W-1:0]   INTERVAL_I,
  output logic [mbpa_pkg::IDX_W-1:0]        CUR_PORT_O,
  output logic                              BUSY_O,
  output logic                              MISS_O,
  output logic                              MON_VALID_O,
  output logic [mbpa_pkg::WORD_W-1:0]       MON_DEST_O,
  output logic [mbpa_pkg::WORD_W-1:0]       MON_DATA_O,
  mbpa_bus_if.ctrl                          bus
);
  localparam int TW = mbpa_pkg::TMR_W;
  localparam int IW = mbpa_pkg::IDX_W;

  typedef struct packed {
    mbpa_pkg::mbpa_ctl_state_t st;
    logic                      poll;
    logic [IW-1:0]             idx;
    logic [TW-1:0]             cnt;
    logic                      go;
    logic                      grant;
    logic                      miss;
    logic                      busy;
  } mbpa_ctl_regs_t;

  mbpa_ctl_regs_t r_reg;
  mbpa_ctl_regs_t r_next;

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    r_next      = r_reg;
    r_next.miss = 1'h0;
    r_next.busy = ~bus.busy_line;
    case (r_reg.st)
      mbpa_pkg::C_IDLE: begin
        // mode only changes between transfers
        r_next.poll = POLL_MODE_I;
        if (ENABLE_I && POLL_MODE_I) begin
          r_next.st  = mbpa_pkg::C_ASK;
          r_next.cnt = TW'(mbpa_pkg::SETTLE_CYC - 1);
        end else if (ENABLE_I && r_reg.cnt == '0) begin
          r_next.st  = mbpa_pkg::C_LAUNCH;
          r_next.go  = 1'h1;
          r_next.cnt = TW'(mbpa_pkg::GO_HOLD_CYC - 1);
        end else if (r_reg.cnt != '0) begin
          r_next.cnt = TW'(r_reg.cnt - TW'(1));
        end
      end
      mbpa_pkg::C_ASK: begin
        // answers are only trusted after the settle time
        if (r_reg.cnt != '0) begin
          r_next.cnt = TW'(r_reg.cnt - TW'(1));
        end else if (bus.req[r_reg.idx]) begin
          r_next.st    = mbpa_pkg::C_GRANT;
          r_next.grant = 1'h1;
          r_next.cnt   = TW'(mbpa_pkg::GRANT_WAIT_CYC - 1);
        end else begin
          // silent port counts as a miss but never stalls the ring
          r_next.miss = ~bus.nodata[r_reg.idx];
          r_next.st   = mbpa_pkg::C_GAP;
          r_next.idx  = IW'(r_reg.idx + IW'(1));
          r_next.cnt  = TW'(mbpa_pkg::SETTLE_CYC - 1);
        end
      end
      mbpa_pkg::C_GRANT: begin
        if (!bus.busy_line) begin
          r_next.st    = mbpa_pkg::C_XFER;
          r_next.grant = 1'h0;
        end else if (r_reg.cnt == '0) begin
          r_next.miss  = 1'h1;
          r_next.grant = 1'h0;
          r_next.st    = mbpa_pkg::C_GAP;
          r_next.idx   = IW'(r_reg.idx + IW'(1));
          r_next.cnt   = TW'(mbpa_pkg::SETTLE_CYC - 1);
        end else begin
          r_next.cnt = TW'(r_reg.cnt - TW'(1));
        end
      end
      mbpa_pkg::C_XFER: begin
        // the sender owns the bus until it lets busy go
        if (bus.busy_line) begin
          r_next.st  = mbpa_pkg::C_GAP;
          r_next.cnt = TW'(mbpa_pkg::SETTLE_CYC - 1);
          if (r_reg.poll) begin
            r_next.idx = IW'(r_reg.idx + IW'(1));
          end
        end
      end
      mbpa_pkg::C_GAP: begin
        if (r_reg.cnt != '0) begin
          r_next.cnt = TW'(r_reg.cnt - TW'(1));
        end else begin
          r_next.st  = mbpa_pkg::C_IDLE;
          r_next.cnt = INTERVAL_I;
        end
      end
      mbpa_pkg::C_LAUNCH: begin
        // go stays up until a requester claims the bus or time runs out
        if (!bus.busy_line) begin
          r_next.st = mbpa_pkg::C_XFER;
          r_next.go = 1'h0;
        end else if (r_reg.cnt == '0) begin
          r_next.st  = mbpa_pkg::C_IDLE;
          r_next.go  = 1'h0;
          r_next.cnt = INTERVAL_I;
        end else begin
          r_next.cnt = TW'(r_reg.cnt - TW'(1));
        end
      end
      default: begin
        r_next = '0;
      end
    endcase
  end

  // state register
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus drives, decoded from registered state
  always_comb begin
    bus.poll_sel = '0;
    bus.grant    = '0;
    if (r_reg.st == mbpa_pkg::C_ASK) begin
      bus.poll_sel[r_reg.idx] = 1'h1;
    end
    bus.grant[r_reg.idx] = r_reg.grant;
  end

  assign bus.poll_mode = r_reg.poll;
  assign bus.go        = r_reg.go;
  assign CUR_PORT_O    = r_reg.idx;
  assign BUSY_O        = r_reg.busy;
  assign MISS_O        = r_reg.miss;

  // passive monitor of every frame on the bus
  mbpa_rx u_mon (
    .clk_i       (REF_CLK_I),
    .rst_n_i     (RESET_N_I),
    .busy_line_i (bus.busy_line),
    .data_line_i (bus.data_line),
    .ignore_i    (1'h0),
    .done_o      (MON_VALID_O),
    .dest_o      (MON_DEST_O),
    .data_o      (MON_DATA_O)
  );
endmodule : mbpa_ctrl

// ===== src/mbpa_port.sv
// bus port end: request, serial transmit, receive and acknowledge
`timescale 1ns/10ps
module mbpa_port #(
  parameter int PORT_ID = 0
) (
  input  wire logic                         REF_CLK_I,
  input  wire logic                         RESET_N_I,
  input  wire logic                         TX_VALID_I,
  input  wire logic [mbpa_pkg::WORD_W-1:0]  TX_DEST_I,
  input  wire logic [mbpa_pkg::WORD_W-1:0]  TX_DATA_I,
  output logic                              TX_READY_O,
  output logic                              TX_DONE_O,
  output logic                              TX_NOACK_O,
  output logic                              RX_VALID_O,
  output logic [mbpa_pkg::WORD_W-1:0]       RX_DATA_O,
  mbpa_bus_if.port                          bus
);
  localparam int FB = mbpa_pkg::FRAME_BITS;
  localparam int CW = mbpa_pkg::CNT_W;
  localparam int NW = mbpa_pkg::NBIT_W;
  localparam int W  = mbpa_pkg::WORD_W;

  typedef struct packed {
    mbpa_pkg::mbpa_tx_state_t st;
    logic [CW-1:0]            cnt;
    logic [NW-1:0]            nbit;
    logic [FB-1:0]            frame;
    logic                     busy_pull;
    logic                     bit_pull;
    logic                     ack_pull;
    logic                     done;
    logic                     noack;
    logic                     rx_valid;
    logic [W-1:0]             rx_data;
  } mbpa_port_regs_t;

  mbpa_port_regs_t r_reg;
  mbpa_port_regs_t r_next;
  logic            rx_done;
  logic [W-1:0]    rx_dest;
  logic [W-1:0]    rx_word;
  logic            pending;
  logic            start;

  // a queued word that has not yet won the bus
  assign pending = (r_reg.st == mbpa_pkg::T_WAIT);
  assign start   = bus.poll_mode ? bus.grant[PORT_ID]
                 : (bus.chain[PORT_ID] & bus.busy_line);

  ////////////////////////////////////////////////////////////////////////
  // transmit sequencer and acknowledge logic
  always_comb begin
    r_next          = r_reg;
    r_next.done     = 1'h0;
    r_next.noack    = 1'h0;
    r_next.rx_valid = 1'h0;
    case (r_reg.st)
      mbpa_pkg::T_IDLE: begin
        if (TX_VALID_I) begin
          r_next.st    = mbpa_pkg::T_WAIT;
          r_next.frame = {TX_DEST_I, TX_DATA_I};
        end
      end
      mbpa_pkg::T_WAIT: begin
        if (start) begin
          r_next.st        = mbpa_pkg::T_LEAD;
          r_next.busy_pull = 1'h1;
          r_next.cnt       = CW'(mbpa_pkg::SETTLE_CYC - 1);
        end
      end
      mbpa_pkg::T_LEAD: begin
        if (r_reg.cnt == '0) begin
          r_next.st       = mbpa_pkg::T_SHIFT;
          r_next.cnt      = CW'(mbpa_pkg::BIT_CYC - 1);
          r_next.nbit     = '0;
          r_next.bit_pull = r_reg.frame[FB-1];
          r_next.frame    = {r_reg.frame[FB-2:0], 1'h0};
        end else begin
          r_next.cnt = CW'(r_reg.cnt - CW'(1));
        end
      end
      mbpa_pkg::T_SHIFT: begin
        // recipient code first, then data, msb first
        if (r_reg.cnt != '0) begin
          r_next.cnt = CW'(r_reg.cnt - CW'(1));
        end else if (r_reg.nbit == NW'(FB - 1)) begin
          r_next.st       = mbpa_pkg::T_ACK;
          r_next.bit_pull = 1'h0;
          r_next.cnt      = CW'(mbpa_pkg::ACK_WAIT_CYC - 1);
        end else begin
          r_next.cnt      = CW'(mbpa_pkg::BIT_CYC - 1);
          r_next.nbit     = NW'(r_reg.nbit + NW'(1));
          r_next.bit_pull = r_reg.frame[FB-1];
          r_next.frame    = {r_reg.frame[FB-2:0], 1'h0};
        end
      end
      mbpa_pkg::T_ACK: begin
        // bounded wait so a dead recipient cannot hold the bus
        if (!bus.ack_line || r_reg.cnt == '0) begin
          r_next.st        = mbpa_pkg::T_REL;
          r_next.busy_pull = 1'h0;
          r_next.noack     = bus.ack_line;
          r_next.cnt       = CW'(mbpa_pkg::SETTLE_CYC - 1);
        end else begin
          r_next.cnt = CW'(r_reg.cnt - CW'(1));
        end
      end
      mbpa_pkg::T_REL: begin
        if (r_reg.cnt == '0) begin
          r_next.st   = mbpa_pkg::T_IDLE;
          r_next.done = 1'h1;
        end else begin
          r_next.cnt = CW'(r_reg.cnt - CW'(1));
        end
      end
      default: begin
        r_next.st = mbpa_pkg::T_IDLE;
      end
    endcase
    // addressed: deliver word, hold ack until the sender lets go
    if (rx_done && rx_dest[PORT_ID]) begin
      r_next.rx_valid = 1'h1;
      r_next.rx_data  = rx_word;
      r_next.ack_pull = 1'h1;
    end else if (bus.busy_line) begin
      r_next.ack_pull = 1'h0;
    end
  end

  // state register
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // poll answers and chain pass-through
  assign bus.req[PORT_ID]    = pending;
  assign bus.nodata[PORT_ID] = bus.poll_sel[PORT_ID] & ~pending;
  assign bus.pass[PORT_ID]   = bus.chain[PORT_ID] & ~pending;

  // open-drain drivers: enable low pulls the line low
  assign bus.data_out[PORT_ID]  = 1'h0;
  assign bus.data_oe_n[PORT_ID] = ~r_reg.bit_pull;
  assign bus.busy_out[PORT_ID]  = 1'h0;
  assign bus.busy_oe_n[PORT_ID] = ~r_reg.busy_pull;
  assign bus.ack_out[PORT_ID]   = 1'h0;
  assign bus.ack_oe_n[PORT_ID]  = ~r_reg.ack_pull;

  assign TX_READY_O = (r_reg.st == mbpa_pkg::T_IDLE);
  assign TX_DONE_O  = r_reg.done;
  assign TX_NOACK_O = r_reg.noack;
  assign RX_VALID_O = r_reg.rx_valid;
  assign RX_DATA_O  = r_reg.rx_data;

  // own frames are not delivered back to this port
  mbpa_rx u_rx (
    .clk_i       (REF_CLK_I),
    .rst_n_i     (RESET_N_I),
    .busy_line_i (bus.busy_line),
    .data_line_i (bus.data_line),
    .ignore_i    (r_reg.busy_pull),
    .done_o      (rx_done),
    .dest_o      (rx_dest),
    .data_o      (rx_word)
  );
endmodule : mbpa_port

// ===== bench/mbpa_chk.sv
// bus checker: grant, poll, go-ahead and driver rules on the shared bus
`timescale 1ns/10ps
module mbpa_chk (
  input wire logic                       REF_CLK_I,
  input wire logic                       RESET_N_I,
  input wire logic [mbpa_pkg::NPORT-1:0] poll_sel,
  input wire logic [mbpa_pkg::NPORT-1:0] grant,
  input wire logic                       go,
  input wire logic [mbpa_pkg::NPORT-1:0] req,
  input wire logic [mbpa_pkg::NPORT-1:0] data_oe_n,
  input wire logic [mbpa_pkg::NPORT-1:0] busy_oe_n,
  input wire logic                       busy_line
);
  // one clock domain, so one default clock and reset for all
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RESET_N_I);
  ////////////////////////////////////////////////////////////////
  // controller side: poll, grant and go-ahead
  a_grant_one_hot: assert property ($onehot0(grant))
    else $error("grant not one-hot");
  a_poll_one_hot: assert property ($onehot0(poll_sel))
    else $error("poll select not one-hot");
  a_grant_after_ask: assert property ($rose(|grant) |->
    grant == $past(poll_sel) && |($past(req) & grant))
    else $error("grant without a pending answer to the poll");
  // ask stands exactly the settle time: first sample plus four more
  a_ask_settle_hold: assert property ($rose(|poll_sel) |=>
    $stable(poll_sel)[*4] ##1 !$stable(poll_sel))
    else $error("poll select not held for the settle time");
  // a grant nobody takes must still be withdrawn, else the bus locks
  a_grant_bounded: assert property ((grant != '0) |->
    ##[1:33] (grant == '0))
    else $error("grant held too long");
  a_go_bounded: assert property ($rose(go) |-> ##[1:10] !go)
    else $error("go-ahead held too long");
  // port side: single owner, data only inside an owned frame
  a_one_talker: assert property ($onehot0(~busy_oe_n))
    else $error("two ports own the bus");
  a_data_in_frame: assert property ((~data_oe_n != '0) |->
    !busy_line)
    else $error("data driven while bus idle");
endmodule : mbpa_chk

// ===== bench/multiplex_bus_poll_arbiter_tb_top.sv
// self-checking bench: controller and four ports on one shared bus
`timescale 1ns/10ps
module multiplex_bus_poll_arbiter_tb_top;
  localparam int N = mbpa_pkg::NPORT;
  localparam int W = mbpa_pkg::WORD_W;
  logic                       clk;
  logic                       rst_n;
  logic                       enable;
  logic                       poll_mode;
  logic [mbpa_pkg::TMR_W-1:0] interval;
  logic [N-1:0]               tx_valid;
  logic [N-1:0]               tx_ready;
  logic [N-1:0]               tx_done;
  logic [N-1:0]               tx_noack;
  logic [N-1:0]               rx_valid;
  logic [W-1:0]               tx_dest [N];
  logic [W-1:0]               tx_data [N];
  logic [W-1:0]               rx_data [N];
  logic                       miss;
  logic [mbpa_pkg::IDX_W-1:0] cur_port;
  logic                       busy;
  logic                       prev_line;
  logic                       mon_valid;
  logic [W-1:0]               mon_dest;
  logic [W-1:0]               mon_data;
  logic [N-1:0]               prev_sel;
  logic [2*W-1:0]             q_mon [$];
  logic [W-1:0]               q_rx [N][$];
  logic [1:0]                 q_end [N][$];
  int                         bad_count;
  int                         tests_run;
  int                         seed;
  int                         polls;
  int                         last_idx;

  mbpa_bus_if bus_if ();
  mbpa_ctrl mbpa_ctrl_inst (.REF_CLK_I(clk), .RESET_N_I(rst_n),
    .ENABLE_I(enable), .POLL_MODE_I(poll_mode), .INTERVAL_I(interval),
    .CUR_PORT_O(cur_port), .BUSY_O(busy), .MISS_O(miss),
    .MON_VALID_O(mon_valid),
    .MON_DEST_O(mon_dest), .MON_DATA_O(mon_data), .bus(bus_if.ctrl));
  for (genvar g = 0; g < N; g++) begin : g_port
    mbpa_port #(.PORT_ID(g)) mbpa_port_inst (
      .REF_CLK_I(clk), .RESET_N_I(rst_n), .TX_VALID_I(tx_valid[g]),
      .TX_DEST_I(tx_dest[g]), .TX_DATA_I(tx_data[g]),
      .TX_READY_O(tx_ready[g]), .TX_DONE_O(tx_done[g]),
      .TX_NOACK_O(tx_noack[g]), .RX_VALID_O(rx_valid[g]),
      .RX_DATA_O(rx_data[g]), .bus(bus_if.port));
  end
  mbpa_chk mbpa_chk_inst (.REF_CLK_I(clk), .RESET_N_I(rst_n),
    .poll_sel(bus_if.poll_sel), .grant(bus_if.grant), .go(bus_if.go),
    .req(bus_if.req), .data_oe_n(bus_if.data_oe_n),
    .busy_oe_n(bus_if.busy_oe_n), .busy_line(bus_if.busy_line));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  // expected monitor frame, receiver words and sender ending
  task automatic note(input int p, input logic [W-1:0] dest,
                      input logic [W-1:0] data);
    logic [N-1:0] to;
    to = dest[N-1:0] & ~(N'(1) << p);
    q_mon.push_back({dest, data});
    for (int r = 0; r < N; r++) begin
      if (to[r]) q_rx[r].push_back(data);
    end
    // an unanswered frame ends in a no-ack pulse, then the done pulse
    if (to == '0) q_end[p].push_back(2'h2);
    q_end[p].push_back(2'h1);
  endtask : note

  // hand one word to a port; held until the taken edge
  task automatic send(input int p, input logic [W-1:0] dest,
                      input logic [W-1:0] data);
    int n;
    n = 0;
    // ready is only trusted once the edge that may lower it has settled
    @(negedge clk);
    while (tx_ready[p] !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) chk("tx ready wait", 16'h0, 16'h1);
    if (n >= 3000) close_out();
    @(posedge clk);
    tx_valid[p] <= 1'b1;
    tx_dest[p]  <= dest;
    tx_data[p]  <= data;
    @(posedge clk);
    tx_valid[p] <= 1'b0;
  endtask : send

  // wait until every noted result was seen, bounded
  task automatic drain(input string what);
    int n;
    int s;
    n = 0;
    s = 1;
    while (s != 0 && n < 20000) begin
      @(negedge clk);
      n++;
      s = q_mon.size();
      for (int r = 0; r < N; r++) s += q_rx[r].size() + q_end[r].size();
    end
    if (s != 0) chk("drain wait", 16'h0, 16'(s));
    if (s != 0) close_out();
    repeat (20) @(posedge clk);
    $display("test %s done", what);
  endtask : drain
  ////////////////////////////////////////////////////////////////
  // watcher: pops the oldest note whenever a result shows up
  always @(negedge clk) begin : watch
    int cur;
    cur = 0;
    if (rst_n === 1'b1) begin
      for (int p = 0; p < N; p++) begin
        if (tx_done[p] === 1'b1 || tx_noack[p] === 1'b1) begin
          if (q_end[p].size() == 0) chk("tx end extra", 16'h0, 16'h1);
          else chk("tx end", 16'(q_end[p].pop_front()),
                   16'({tx_noack[p], tx_done[p]}));
        end
        if (rx_valid[p] === 1'b1) begin
          if (q_rx[p].size() == 0) chk("rx extra", 16'h0, 16'h1);
          else chk("rx data", 16'(q_rx[p].pop_front()),
                   16'(rx_data[p]));
        end
      end
      if (mon_valid === 1'b1) begin
        if (q_mon.size() == 0) chk("frame extra", 16'h0, 16'h1);
        else chk("frame", q_mon.pop_front(),
                 {mon_dest, mon_data});
      end
      if (miss === 1'b1) chk("miss pulse", 16'h0, 16'h1);
      // poll order is checked across idle answers and transfers alike
      if (bus_if.poll_mode !== 1'b1) begin
        last_idx = -1;
      end else if (prev_sel == '0 && bus_if.poll_sel != '0) begin
        for (int i = 0; i < N; i++) begin
          if (bus_if.poll_sel[i]) cur = i;
        end
        if (last_idx >= 0)
          chk("poll order", 16'((last_idx + 1) % N), 16'(cur));
        chk("cur port", 16'(cur), 16'(cur_port));
        last_idx = cur;
        polls++;
      end
      prev_sel = bus_if.poll_sel;
      // busy flag follows the shared line one clock late
      chk("busy flag", prev_line ? 16'h0 : 16'h1, 16'(busy));
      prev_line = bus_if.busy_line;
    end
  end

  // main sequence
  initial begin : main
    logic [W-1:0] d;
    logic [W-1:0] m;
    seed = 32'hEA8E;
    rst_n = 1'b0;
    enable = 1'b0;
    poll_mode = 1'b0;
    interval = 16'h0040;
    tx_valid = '0;
    tx_dest = '{default: '0};
    tx_data = '{default: '0};
    prev_sel = '0;
    prev_line = 1'b1;
    bad_count = 0;
    tests_run = 0;
    polls = 0;
    last_idx = -1;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // polled, nobody has data: every port answers no-data
    @(posedge clk);
    poll_mode <= 1'b1;
    enable <= 1'b1;
    repeat (150) @(posedge clk);
    chk("polls seen", 16'h1, 16'(polls >= 2 * N));
    $display("test poll_idle done");
    // polled: two back-to-back words from each port in turn
    for (int p = 0; p < N; p++) begin
      m = W'($random(seed)) | W'(N'(1) << ((p + 1) % N));
      for (int k = 0; k < 2; k++) begin
        d = W'($random(seed));
        note(p, m, d);
        send(p, m, d);
      end
      drain("poll_xfer");
    end
    // only the sender itself addressed: sender must give up and release
    note(0, 8'hA1, 8'h5A);
    send(0, 8'hA1, 8'h5A);
    drain("no_ack");
    // async: three requesters, lowest chain position first
    enable <= 1'b0;
    repeat (20) @(posedge clk);
    poll_mode <= 1'b0;
    m = W'($random(seed)) | 8'h01;
    d = W'($random(seed));
    for (int p = 1; p < N; p++) note(p, m, d + W'(p));
    for (int p = N - 1; p > 0; p--) send(p, m, d + W'(p));
    @(posedge clk);
    enable <= 1'b1;
    drain("async_chain");
    close_out();
  end
endmodule : multiplex_bus_poll_arbiter_tb_top
